// ---- verilog/sac_adc_ctrl.sv ----
// digital control of a 10-bit SAR converter: APB registers, clock divider,
// start selection, bit-by-bit approximation and result formatting
// assumes the analog core compares its held input against trialCode on cmpAbove
//
// What this block does
// - converter runs only while enable bit set
// - sixteen port inputs, positive and negative independent
// - separate positive and negative channel select registers
// - ground negative means single-ended, else differential
// - temperature sensor code routes sensor to positive
// - completion loads high and low result bytes
// - single-ended result is 10-bit unsigned
// - differential result is 10-bit two's complement
// - justify bit picks right or left placement
// - single-ended unused result bits read zero
// - right-justified differential upper bits sign-extended
// - left-justified differential lower bits zero
// - conversion clock is system clock over divider+1
// - 3-bit field selects the start source
// - sources: software, t0, t2, t1, pin edge, t3
// - busy during conversion, completion sets done as busy falls
// - low-power tracking adds three conversion clocks
// - timers 2/3 use low or high overflow by mode
module sac_adc_ctrl (
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  input  wire logic                      timer0Ovf,
  input  wire logic                      timer1Ovf,
  input  wire logic                      timer2LowOvf,
  input  wire logic                      timer2HighOvf,
  input  wire logic                      timer2Split8,
  input  wire logic                      timer3LowOvf,
  input  wire logic                      timer3HighOvf,
  input  wire logic                      timer3Split8,
  input  wire logic                      externalConvertStart,
  input  wire logic                      cmpAbove,
  output logic                           adcPowerOn,
  output logic                           adcTrack,
  output logic [sac_pkg::CH_W-1:0]       posSel,
  output logic [sac_pkg::CH_W-1:0]       negSel,
  output logic [sac_pkg::RES_W-1:0]      trialCode,
  output logic                           convClkTick,
  output logic                           conversionDone
);
  // format one result into the high:low pair
  function automatic logic [15:0] fmtResult(input logic [9:0] sar, input logic diff,
                                            input logic ljst);
    logic [9:0] v;
    // flipping the msb turns the offset-binary code into two's complement
    v = diff ? {~sar[9], sar[8:0]} : sar;
    if (ljst)
      fmtResult = {v, 6'h00};
    else if (diff)
      fmtResult = {{6{v[9]}}, v};
    else
      fmtResult = {6'h00, v};
  endfunction : fmtResult

  // released through two flops so all state leaves reset on one edge
  logic        rstSync1_q;
  logic        rstN;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstSync1_q <= 1'b0;
      rstN       <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstN       <= rstSync1_q;
    end
  end

  logic [4:0]  posSel_q;
  logic [4:0]  negSel_q;
  logic [4:0]  div_q;
  logic [4:0]  divCnt_q;
  logic        ljst_q;
  logic        en_q;
  logic        lpTrack_q;
  logic        done_q;
  logic        ready_q;
  logic        err_q;
  logic        extPrev_q;
  logic        tick_q;
  logic [2:0]  src_q;
  logic [15:0] result_q;
  logic [31:0] rdata_q;
  logic [9:0]  trial_q;
  logic [3:0]  bitIdx_q;
  logic [1:0]  trackCnt_q;
  sac_pkg::sac_state_t state_q;

  // bus decode
  wire         setupPh  = psel && !penable;
  wire         wrStrobe = psel && penable && ready_q && pwrite && !err_q;
  wire         hitPos   = paddr == sac_pkg::OFS_POS_SEL;
  wire         hitNeg   = paddr == sac_pkg::OFS_NEG_SEL;
  wire         hitCfg   = paddr == sac_pkg::OFS_CONFIG;
  wire         hitHigh  = paddr == sac_pkg::OFS_RES_HIGH;
  wire         hitLow   = paddr == sac_pkg::OFS_RES_LOW;
  wire         hitCtl   = paddr == sac_pkg::OFS_CONTROL;
  wire         mapped   = hitPos || hitNeg || hitCfg || hitHigh || hitLow || hitCtl;
  wire         busy     = state_q != sac_pkg::ST_IDLE;
  wire [7:0]   ctlRead  = {1'b0, src_q, busy, done_q, lpTrack_q, en_q};
  wire [7:0]   cfgRead  = {div_q, ljst_q, 2'b00};
  wire [7:0]   rdMux    = hitPos  ? {3'b000, posSel_q} :
                          hitNeg  ? {3'b000, negSel_q} :
                          hitCfg  ? cfgRead :
                          hitHigh ? result_q[15:8] :
                          hitLow  ? result_q[7:0] :
                          hitCtl  ? ctlRead : 8'h00;
  wire         ctlWr    = wrStrobe && hitCtl;

  // differential whenever ground is not the negative input
  wire         diffMode = negSel_q != sac_pkg::NEG_GND;

  // start source selection; timers 2/3 pick overflow by their width
  wire         tmr2Ovf  = timer2Split8 ? timer2LowOvf : timer2HighOvf;
  wire         tmr3Ovf  = timer3Split8 ? timer3LowOvf : timer3HighOvf;
  // extPrev_q resets low, so a pin held high through reset reads as a rising edge on the first cycle
  wire         extRise  = externalConvertStart && !extPrev_q;
  wire         softGo   = ctlWr && pwdata[sac_pkg::CTL_BUSY_BIT];
  logic        trigger;
  always_comb begin
    unique case (src_q)
      sac_pkg::SRC_SOFT: trigger = softGo;
      sac_pkg::SRC_TMR0: trigger = timer0Ovf;
      sac_pkg::SRC_TMR2: trigger = tmr2Ovf;
      sac_pkg::SRC_TMR1: trigger = timer1Ovf;
      sac_pkg::SRC_EXT:  trigger = extRise;
      sac_pkg::SRC_TMR3: trigger = tmr3Ovf;
      // codes 6 and 7 never start a conversion
      default:           trigger = 1'b0;
    endcase
  end
  // a trigger while busy or disabled is dropped, not queued
  wire         startConv = trigger && en_q && !busy;

  // conversion clock enable: one pulse every div+1 system clocks
  wire         divWrap  = divCnt_q == div_q;
  wire         lastBit  = bitIdx_q == 4'h0;
  wire         finish   = state_q == sac_pkg::ST_CONV && tick_q && lastBit;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ready_q <= setupPh;
      err_q   <= setupPh && !mapped;
      // read data frozen at setup, so a status change during access cannot tear it
      if (setupPh)
        rdata_q <= {24'h00_0000, rdMux};
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN)
      posSel_q <= sac_pkg::RST_CH_SEL;
    else if (wrStrobe && hitPos)
      posSel_q <= pwdata[4:0];
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN)
      negSel_q <= sac_pkg::RST_CH_SEL;
    else if (wrStrobe && hitNeg)
      negSel_q <= pwdata[4:0];
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      div_q  <= sac_pkg::RST_DIV;
      ljst_q <= 1'b0;
    end else if (wrStrobe && hitCfg) begin
      div_q  <= pwdata[sac_pkg::CFG_DIV_LSB +: sac_pkg::DIV_W];
      ljst_q <= pwdata[sac_pkg::CFG_LJST_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      en_q      <= 1'b0;
      lpTrack_q <= 1'b0;
      src_q     <= sac_pkg::SRC_SOFT;
    end else if (ctlWr) begin
      en_q      <= pwdata[sac_pkg::CTL_EN_BIT];
      lpTrack_q <= pwdata[sac_pkg::CTL_TRACK_BIT];
      src_q     <= pwdata[sac_pkg::CTL_SRC_LSB +: 3];
    end
  end

  // done flag: hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN)
      done_q <= 1'b0;
    else if (finish)
      done_q <= 1'b1;
    else if (ctlWr && !pwdata[sac_pkg::CTL_DONE_BIT])
      done_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      divCnt_q  <= 5'h00;
      tick_q    <= 1'b0;
      extPrev_q <= 1'b0;
    end else begin
      extPrev_q <= externalConvertStart;
      // divider held in reset while disabled to save power
      divCnt_q  <= (!en_q || divWrap) ? 5'h00 : divCnt_q + 5'h01;
      tick_q    <= en_q && divWrap;
    end
  end

  // approximation sequencer, starting on any cycle, then advancing on conversion clock ticks only
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      state_q    <= sac_pkg::ST_IDLE;
      trial_q    <= 10'h000;
      bitIdx_q   <= 4'h0;
      trackCnt_q <= 2'h0;
      result_q   <= 16'h0000;
    end else if (!en_q) begin
      // disabling mid-conversion aborts: old result kept, no done flag unless the last tick lands in the first disabled cycle
      state_q <= sac_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        sac_pkg::ST_IDLE: if (startConv) begin
          trial_q    <= 10'h200;
          bitIdx_q   <= 4'h9;
          trackCnt_q <= 2'h0;
          state_q    <= lpTrack_q ? sac_pkg::ST_TRACK : sac_pkg::ST_CONV;
        end
        sac_pkg::ST_TRACK: if (tick_q) begin
          trackCnt_q <= trackCnt_q + 2'h1;
          if (trackCnt_q == sac_pkg::TRACK_CLKS - 2'h1)
            state_q <= sac_pkg::ST_CONV;
        end
        sac_pkg::ST_CONV: if (tick_q) begin
          // trialCode changed at the previous tick, or on the start edge for the first trial
          if (!cmpAbove)
            trial_q[bitIdx_q] <= 1'b0;
          if (lastBit) begin
            state_q  <= sac_pkg::ST_IDLE;
            // both bytes in one write, so the two result registers never hold halves of different results
            result_q <= fmtResult({trial_q[9:1], cmpAbove ? trial_q[0] : 1'b0},
                                  diffMode, ljst_q);
          end else begin
            trial_q[bitIdx_q - 4'h1] <= 1'b1;
            bitIdx_q                 <= bitIdx_q - 4'h1;
          end
        end
      endcase
    end
  end

  // analog-facing outputs, all registered
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      adcPowerOn <= 1'b0;
      adcTrack   <= 1'b0;
      posSel     <= sac_pkg::RST_CH_SEL;
      negSel     <= sac_pkg::RST_CH_SEL;
    end else begin
      adcPowerOn <= en_q;
      // continuous tracking unless low-power mode or converting
      adcTrack   <= en_q && (lpTrack_q ? state_q == sac_pkg::ST_TRACK
                                       : state_q != sac_pkg::ST_CONV);
      posSel     <= posSel_q;
      negSel     <= negSel_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      convClkTick    <= 1'b0;
      conversionDone <= 1'b0;
    end else begin
      convClkTick    <= tick_q;
      conversionDone <= finish;
    end
  end

  assign pready  = ready_q;
  assign pslverr = err_q;
  assign prdata  = rdata_q;
  // trial code leaves straight from its register so the comparator sees it at once
  assign trialCode = trial_q;
  // is the programmer's duty; the divider does not enforce a rate limit
endmodule : sac_adc_ctrl

// ---- verilog/sac_pkg.sv ----
// register map, field positions, reset values and states of the converter control block
// assumes a 32-bit APB master and an analog SAR core with a comparator output
package sac_pkg;
  localparam int          RES_W         = 10;
  localparam int          CH_W          = 5;
  localparam int          DIV_W         = 5;
  // register byte offsets
  localparam logic [7:0]  OFS_POS_SEL   = 8'h00;
  localparam logic [7:0]  OFS_NEG_SEL   = 8'h04;
  localparam logic [7:0]  OFS_CONFIG    = 8'h08;
  localparam logic [7:0]  OFS_RES_HIGH  = 8'h0c;
  localparam logic [7:0]  OFS_RES_LOW   = 8'h10;
  localparam logic [7:0]  OFS_CONTROL   = 8'h14;
  // reset values
  localparam logic [4:0]  RST_CH_SEL    = 5'h1f;
  localparam logic [4:0]  RST_DIV       = 5'h1f;
  // channel codes
  localparam logic [4:0]  POS_TEMP      = 5'h10;
  localparam logic [4:0]  NEG_GND       = 5'h11;
  // config register fields
  localparam int          CFG_DIV_LSB   = 3;
  localparam int          CFG_LJST_BIT  = 2;
  // control register fields
  localparam int          CTL_EN_BIT    = 0;
  localparam int          CTL_TRACK_BIT = 1;
  localparam int          CTL_DONE_BIT  = 2;
  localparam int          CTL_BUSY_BIT  = 3;
  localparam int          CTL_SRC_LSB   = 4;
  // start sources
  localparam logic [2:0]  SRC_SOFT      = 3'h0;
  localparam logic [2:0]  SRC_TMR0      = 3'h1;
  localparam logic [2:0]  SRC_TMR2      = 3'h2;
  localparam logic [2:0]  SRC_TMR1      = 3'h3;
  localparam logic [2:0]  SRC_EXT       = 3'h4;
  localparam logic [2:0]  SRC_TMR3      = 3'h5;
  // cycle counts, in conversion clocks
  localparam logic [1:0]  TRACK_CLKS    = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONV} sac_state_t;
endpackage : sac_pkg

// ---- dv/sac_adc_monitor.sv ----
// assertions on the bus answer and the conversion pulses of the converter control block
// assumes binding into sac_adc_ctrl, one clock and an active-low asynchronous reset
module sac_adc_monitor (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        adcPowerOn,
  input wire logic        convClkTick,
  input wire logic        conversionDone
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence sqSetup;
    psel && !penable;
  endsequence
  sequence sqAnswer;
    pready ##1 !pready;
  endsequence
  chk_ready_after_setup: assert property (sqSetup |=> sqAnswer)
    else $error("no single ready after setup");
  chk_ready_needs_setup: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  chk_err_with_ready: assert property (pslverr |-> pready && psel)
    else $error("error flag outside an answer");
  chk_read_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_off_quiet: assert property (!adcPowerOn && !$past(adcPowerOn) |->
    !convClkTick && !conversionDone)
    else $error("activity while shut down");
  chk_done_single: assert property (conversionDone |=> !conversionDone)
    else $error("done pulse too long");
  chk_done_after_tick: assert property (conversionDone |-> convClkTick)
    else $error("done without a conversion clock");
  chk_power_by_write: assert property ($changed(adcPowerOn) |->
    $past(psel && penable && pready && pwrite && paddr == sac_pkg::OFS_CONTROL, 2))
    else $error("power changed without a control write");
endmodule : sac_adc_monitor
bind sac_adc_ctrl sac_adc_monitor i_sac_adc_monitor (.clk_sys(clk_sys), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .adcPowerOn(adcPowerOn), .convClkTick(convClkTick),
  .conversionDone(conversionDone));

// ---- dv/sac_analog_model.sv ----
// behavioural analog core: comparator of the selected input code against the trial code
// assumes offset-binary trial codes, 1 meaning the input is at or above the trial
module sac_analog_model #(
  parameter logic [9:0] TEMP_CODE = 10'h2a5
) (
  input  wire logic       clk_sys,
  input  wire logic       adcPowerOn,
  input  wire logic [4:0] posSel,
  input  wire logic [9:0] trialCode,
  input  wire logic [9:0] level,
  output logic            cmpAbove
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       junk_q = 1'b0;
  logic [9:0] picked;
  // unpowered output toggles, so a stale comparison can never pass for a result
  always_ff @(posedge clk_sys) junk_q <= ~junk_q;
  assign picked   = (posSel == sac_pkg::POS_TEMP) ? TEMP_CODE : level;
  assign cmpAbove = adcPowerOn ? (picked >= trialCode) : junk_q;
endmodule : sac_analog_model

// ---- dv/tb_top.sv ----
// self-checking bench of the converter control block with an analog core model
// assumes an APB slave answering in its own time and a 25 MHz system clock
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] TEMP = 10'h2a5;
  localparam logic [7:0] ADR [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  localparam logic [7:0] RST [7] = '{8'h1f, 8'h1f, 8'hf8, 8'h00, 8'h00, 8'h00, 8'h00};
  logic        clk_sys = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [6:0]  trig = 7'h00;
  logic        split = 1'b1;
  logic [9:0]  level = 10'h000, trialCode;
  logic [4:0]  posSel, negSel;
  logic        pready, pslverr, rErr, cmpAbove, adcPowerOn, adcTrack, convClkTick, conversionDone;
  int          errors = 0, checks = 0, cycles = 0;
  always #20 clk_sys = ~clk_sys;
  sac_adc_ctrl i_sac_adc_ctrl (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .timer0Ovf(trig[0]), .timer1Ovf(trig[1]), .timer2LowOvf(trig[2]),
    .timer2HighOvf(trig[3]), .timer2Split8(split), .timer3LowOvf(trig[4]), .timer3HighOvf(trig[5]),
    .timer3Split8(split), .externalConvertStart(trig[6]), .cmpAbove(cmpAbove),
    .adcPowerOn(adcPowerOn), .adcTrack(adcTrack), .posSel(posSel), .negSel(negSel),
    .trialCode(trialCode), .convClkTick(convClkTick), .conversionDone(conversionDone));
  sac_analog_model #(.TEMP_CODE(TEMP)) i_sac_analog_model (.clk_sys(clk_sys),
    .adcPowerOn(adcPowerOn), .posSel(posSel), .trialCode(trialCode), .level(level),
    .cmpAbove(cmpAbove));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no timeout here: pready ends this wait, or else the bench ceiling
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata;
    rErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pulse(input int i);
    @(posedge clk_sys);
    trig[i] <= 1'b1;
    @(posedge clk_sys);
    trig[i] <= 1'b0;
  endtask : pulse
  // counts conversion clocks seen after the start edge until the done pulse
  task automatic wait_done(output int ticks);
    ticks = 0;
    // the first sample shows a tick of the start edge itself, which the design ignores
    @(posedge clk_sys);
    while (conversionDone !== 1'b1) begin
      @(posedge clk_sys);
      ticks += (convClkTick === 1'b1);
    end
  endtask : wait_done
  function automatic logic [15:0] fmt(input logic [9:0] c, input logic diff, input logic lj);
    logic [9:0] v;
    v = diff ? c ^ 10'h200 : c;
    return lj ? {v, 6'h00} : {{6{diff & v[9]}}, v};
  endfunction : fmt
  task automatic test_reset();
    apb(1'b1, 8'h0c, 32'hff);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ADR[i], 32'h0);
      chk(r, {24'h0, RST[i]});
      chk({31'h0, rErr}, {31'h0, i == 6});
    end
    $display("reset test done");
  endtask : test_reset
  task automatic test_conv(input logic [4:0] p, input logic [4:0] m, input logic lj,
                           input logic tr, input logic [9:0] lv);
    int          t;
    logic [15:0] e;
    e = fmt(p == sac_pkg::POS_TEMP ? TEMP : lv, m != sac_pkg::NEG_GND, lj);
    level <= lv;
    apb(1'b1, 8'h00, {27'h0, p});
    apb(1'b1, 8'h04, {27'h0, m});
    apb(1'b1, 8'h08, {24'h0, 5'h0b, lj, 2'b00});
    apb(1'b1, 8'h14, {30'h0, tr, 1'b1});
    apb(1'b1, 8'h14, {28'h0, 2'b10, tr, 1'b1});
    wait_done(t);
    chk(t, tr ? 32'd13 : 32'd10);
    apb(1'b0, 8'h0c, 32'h0);
    chk(r, {24'h0, e[15:8]});
    apb(1'b0, 8'h10, 32'h0);
    chk(r, {24'h0, e[7:0]});
    apb(1'b0, 8'h14, 32'h0);
    chk({28'h0, r[3:0]}, {28'h0, 2'b01, tr, 1'b1});
    chk({27'h0, posSel}, {27'h0, p});
    chk({27'h0, negSel}, {27'h0, m});
    chk({31'h0, adcTrack}, {31'h0, !tr});
    $display("conversion test %h %h done", p, m);
  endtask : test_conv
  task automatic test_div(input logic [4:0] d);
    int n;
    apb(1'b1, 8'h08, {24'h0, d, 3'h0});
    // enable only: the divider runs whenever enabled, no conversion at this rate
    apb(1'b1, 8'h14, 32'h1);
    n = 0;
    while (convClkTick !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (convClkTick !== 1'b1 && n < 100);
    chk(n, {27'h0, d} + 32'h1);
    $display("divider test %h done", d);
  endtask : test_div
  task automatic test_src(input logic sp);
    int right;
    int t;
    split <= sp;
    for (int s = 1; s < 6; s++) begin
      right = s == 1 ? 0 : s == 2 ? (sp ? 2 : 3) : s == 3 ? 1 : s == 4 ? 6 : (sp ? 4 : 5);
      apb(1'b1, 8'h14, {25'h0, 3'(s), 4'h1});
      for (int i = 0; i < 7; i++)
        if (i != right) pulse(i);
      repeat (3) @(posedge clk_sys);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, r[3]}, 32'h0);
      pulse(right);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, r[3]}, 32'h1);
      pulse(right);
      wait_done(t);
      repeat (3) @(posedge clk_sys);
      apb(1'b0, 8'h14, 32'h0);
      chk({28'h0, r[3:0]}, 32'h5);
    end
    $display("start source test done");
  endtask : test_src
  task automatic test_off();
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b1, 8'h14, 32'h8);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, adcPowerOn}, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(r, 32'h0);
    $display("shutdown test done");
  endtask : test_off
  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // ceiling well above the few thousand cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    test_reset();
    test_conv(5'h0f, sac_pkg::NEG_GND, 1'b0, 1'b0, 10'h3ff);
    test_conv(5'h00, sac_pkg::NEG_GND, 1'b1, 1'b1, 10'h3ff);
    test_conv(5'h05, sac_pkg::NEG_GND, 1'b1, 1'b0, 10'h201);
    test_conv(5'h01, 5'h0f, 1'b0, 1'b0, 10'h100);
    test_conv(5'h01, 5'h10, 1'b1, 1'b0, 10'h2ff);
    test_conv(sac_pkg::POS_TEMP, sac_pkg::NEG_GND, 1'b0, 1'b0, 10'h000);
    test_div(5'h00);
    test_div(5'h1f);
    test_src(1'b1);
    test_src(1'b0);
    test_off();
    close_out();
  end
endmodule : tb_top
